// >>> rtl/tpu_timer_pwm_unit.sv
// Purpose: 16-bit timer, counter and pwm unit with apb registers
// Assumes: one 250 mhz clock, synchronous active-low reset
// Notes: kill and capture pins are synchronised with two flops
//
// Notes on behaviour
// RULE_01 - sixteen bit counter, period length set by software register
// RULE_02 - capture event latches current count into capture register
// RULE_03 - at count equal period, stop or reload per one-shot mode
// RULE_04 - count compared with two compare values forms pwm duty
// RULE_05 - true and complement outputs separated by programmable dead gap
// RULE_06 - kill input forces outputs to programmed safe levels
// RULE_07 - kill acts in hardware, no software step needed
// RULE_08 - counter steps once per running clock, settings take sync effect
`timescale 1ns/100ps
module tpu_timer_pwm_unit
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pins
   input wire logic capture_pin_i,
   input wire logic kill_pin_i,
   output logic pwm_o,
   output logic pwm_n_o,
   output tpu_pkg::tpu_out_t status_o
);
   import tpu_pkg::*;

   // =====================================================
   // all state in one struct
   typedef struct packed {
      logic [TPU_CTRL_W-1:0] ctrl;
      tpu_cnt_t period;
      tpu_cnt_t cmp0;
      tpu_cnt_t cmp1;
      logic [7:0] dead;
      tpu_cnt_t count;
      tpu_cnt_t capture;
      logic running;
      logic capt_flag;
      logic tc_flag;
      logic line;
      logic [1:0] cap_sync;
      logic [1:0] kill_sync;
      logic cap_prev;
      logic [31:0] rdata;
      tpu_out_t outs;
   } tpu_state_t;

   tpu_state_t s_q;
   tpu_state_t s_d;
   logic db_true;
   logic db_comp;
   logic wr_en;
   logic rd_en;
   logic cap_edge;
   logic at_period;
   logic kill_now;
   logic [31:0] rd_mux;

   // zero-extend a 16-bit value to a bus word
   function automatic logic [31:0] tpu_word(input tpu_cnt_t v);
      tpu_word = {TPU_ZERO16, v};
   endfunction : tpu_word

   // =====================================================
   // apb strobes: zero wait state, every access completes at once
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o = 1'b1;

   // unmapped addresses answer with an error
   always_comb
   begin
      pslverr_o = 1'b0;
      if (psel_i && penable_i)
      begin
         if (paddr_i == TPU_ADDR_CTRL) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_PERIOD) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_CMP0) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_CMP1) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_DEAD) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_COUNT) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_CAPTURE) pslverr_o = 1'b0;
         else if (paddr_i == TPU_ADDR_STATUS) pslverr_o = 1'b0;
         else pslverr_o = 1'b1;
      end
   end

   // read mux, sampled in the setup phase into a flop
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (paddr_i == TPU_ADDR_CTRL)
         rd_mux = {25'h000_0000, s_q.ctrl};
      else if (paddr_i == TPU_ADDR_PERIOD)
         rd_mux = tpu_word(s_q.period);
      else if (paddr_i == TPU_ADDR_CMP0)
         rd_mux = tpu_word(s_q.cmp0);
      else if (paddr_i == TPU_ADDR_CMP1)
         rd_mux = tpu_word(s_q.cmp1);
      else if (paddr_i == TPU_ADDR_DEAD)
         rd_mux = {24'h00_0000, s_q.dead};
      else if (paddr_i == TPU_ADDR_COUNT)
         rd_mux = tpu_word(s_q.count);
      else if (paddr_i == TPU_ADDR_CAPTURE)
         rd_mux = tpu_word(s_q.capture);
      else if (paddr_i == TPU_ADDR_STATUS)
         rd_mux = {28'h000_0000, s_q.tc_flag, s_q.capt_flag,
                   s_q.outs.killed, s_q.running};
   end
   assign prdata_o = s_q.rdata;

   // =====================================================
   // synchronised pin events
   assign cap_edge = s_q.ctrl[TPU_CTRL_CAP_FALL]
                     ? (s_q.cap_prev & ~s_q.cap_sync[1])
                     : (~s_q.cap_prev & s_q.cap_sync[1]);
   assign kill_now = s_q.kill_sync[1]; // RULE_07
   assign at_period = (s_q.count == s_q.period);

   // =====================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      s_d.cap_sync = {s_q.cap_sync[0], capture_pin_i};
      s_d.kill_sync = {s_q.kill_sync[0], kill_pin_i};
      s_d.cap_prev = s_q.cap_sync[1];
      s_d.ctrl[TPU_CTRL_START] = 1'b0; // start is a self-clearing strobe
      if (rd_en)
         s_d.rdata = rd_mux;

      // counter: one step per running cycle
      if (s_q.running)
      begin
         if (at_period)
         begin
            s_d.tc_flag = 1'b1;
            s_d.count = TPU_ZERO16; // RULE_03
            if (s_q.ctrl[TPU_CTRL_ONESHOT])
               s_d.running = 1'b0; // RULE_03
         end
         else
            s_d.count = s_q.count + TPU_ONE16; // RULE_01 RULE_08
      end
      if (s_q.ctrl[TPU_CTRL_START] && s_q.ctrl[TPU_CTRL_RUN])
         s_d.running = 1'b1;
      if (!s_q.ctrl[TPU_CTRL_RUN])
         s_d.running = 1'b0;

      // capture on the selected pin edge
      if (cap_edge && s_q.ctrl[TPU_CTRL_CAP_EN])
      begin
         s_d.capture = s_q.count; // RULE_02
         s_d.capt_flag = 1'b1;
      end

      // pwm level: high from cmp0 up to cmp1
      if (s_q.count == s_q.cmp0)
         s_d.line = 1'b1; // RULE_04
      if (s_q.count == s_q.cmp1)
         s_d.line = 1'b0; // RULE_04
      if (!s_q.running)
         s_d.line = 1'b0;

      // kill overrides the compare-driven outputs
      s_d.outs.killed = kill_now;
      if (kill_now)
      begin
         s_d.outs.pwm_n = s_q.ctrl[TPU_CTRL_KILL_LVL]; // RULE_06
         s_d.outs.pwm_c = s_q.ctrl[TPU_CTRL_KILL_COMP]; // RULE_06
      end
      else
      begin
         s_d.outs.pwm_n = db_true;
         s_d.outs.pwm_c = db_comp;
      end

      // register writes take effect at the access edge
      if (wr_en)
      begin
         if (paddr_i == TPU_ADDR_CTRL)
            s_d.ctrl = pwdata_i[TPU_CTRL_W-1:0];
         else if (paddr_i == TPU_ADDR_PERIOD)
            s_d.period = pwdata_i[TPU_CNT_W-1:0]; // RULE_08
         else if (paddr_i == TPU_ADDR_CMP0)
            s_d.cmp0 = pwdata_i[TPU_CNT_W-1:0];
         else if (paddr_i == TPU_ADDR_CMP1)
            s_d.cmp1 = pwdata_i[TPU_CNT_W-1:0];
         else if (paddr_i == TPU_ADDR_DEAD)
            s_d.dead = pwdata_i[7:0];
         else if (paddr_i == TPU_ADDR_COUNT)
            s_d.count = pwdata_i[TPU_CNT_W-1:0];
         else if (paddr_i == TPU_ADDR_STATUS)
         begin
            // write one to clear; a new event in this cycle wins
            if (pwdata_i[TPU_STAT_CAPT] && !(cap_edge &&
                s_q.ctrl[TPU_CTRL_CAP_EN]))
               s_d.capt_flag = 1'b0;
            if (pwdata_i[TPU_STAT_TC] && !(s_q.running && at_period))
               s_d.tc_flag = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         s_q <= '0;
         s_q.period <= TPU_PERIOD_RST;
         s_q.cmp0 <= TPU_CMP_RST;
         s_q.cmp1 <= TPU_CMP_RST;
         s_q.dead <= TPU_DEAD_RST;
      end
      else
         s_q <= s_d;
   end

   // =====================================================
   // dead-band splitter
   tpu_deadband u_db
   (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .dead_i(s_q.dead),
      .line_i(s_q.line),
      .true_o(db_true),
      .comp_o(db_comp)
   );

   // outputs come straight from flops
   assign pwm_o = s_q.outs.pwm_n;
   assign pwm_n_o = s_q.outs.pwm_c;
   assign status_o = s_q.outs;

endmodule : tpu_timer_pwm_unit

// >>> rtl/tpu_pkg.sv
// Purpose: shared constants and types for the timer and pwm unit
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
package tpu_pkg;

   // =====================================================
   // register map
   localparam logic [7:0] TPU_ADDR_CTRL = 8'h00;
   localparam logic [7:0] TPU_ADDR_PERIOD = 8'h04;
   localparam logic [7:0] TPU_ADDR_CMP0 = 8'h08;
   localparam logic [7:0] TPU_ADDR_CMP1 = 8'h0c;
   localparam logic [7:0] TPU_ADDR_DEAD = 8'h10;
   localparam logic [7:0] TPU_ADDR_COUNT = 8'h14;
   localparam logic [7:0] TPU_ADDR_CAPTURE = 8'h18;
   localparam logic [7:0] TPU_ADDR_STATUS = 8'h1c;

   // =====================================================
   // control field positions
   localparam int TPU_CTRL_RUN = 0;
   localparam int TPU_CTRL_ONESHOT = 1;
   localparam int TPU_CTRL_CAP_EN = 2;
   localparam int TPU_CTRL_CAP_FALL = 3;
   localparam int TPU_CTRL_KILL_LVL = 4;
   localparam int TPU_CTRL_KILL_COMP = 5;
   localparam int TPU_CTRL_START = 6;
   localparam int TPU_CTRL_W = 7;

   // status field positions
   localparam int TPU_STAT_RUN = 0;
   localparam int TPU_STAT_KILL = 1;
   localparam int TPU_STAT_CAPT = 2;
   localparam int TPU_STAT_TC = 3;

   // =====================================================
   // reset values and widths
   localparam int TPU_CNT_W = 16;
   localparam logic [15:0] TPU_PERIOD_RST = 16'hffff;
   localparam logic [15:0] TPU_CMP_RST = 16'h0000;
   localparam logic [15:0] TPU_ZERO16 = 16'h0000;
   localparam logic [15:0] TPU_ONE16 = 16'h0001;
   localparam logic [7:0] TPU_DEAD_RST = 8'h00;
   localparam logic [7:0] TPU_ZERO8 = 8'h00;
   localparam logic [7:0] TPU_ONE8 = 8'h01;

   // =====================================================
   // types
   typedef logic [TPU_CNT_W-1:0] tpu_cnt_t;

   typedef struct packed {
      logic pwm_n;
      logic pwm_c;
      logic killed;
   } tpu_out_t;

   typedef enum logic [1:0] {
      TPU_DB_LOW = 2'b00,
      TPU_DB_WAIT_HI = 2'b01,
      TPU_DB_HIGH = 2'b10,
      TPU_DB_WAIT_LO = 2'b11
   } tpu_db_state_t;

endpackage : tpu_pkg

// >>> rtl/tpu_deadband.sv
// Purpose: split one pwm level into true and complementary outputs
// Assumes: line input is a registered level on core_clk_i
// Notes: each output turns on after dead+1 cycles of both being off, or after 2 if the line turns back during the gap
`timescale 1ns/100ps
module tpu_deadband
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic [7:0] dead_i,
   input wire logic line_i,
   // outputs
   output logic true_o,
   output logic comp_o
);
   import tpu_pkg::*;

   typedef struct packed {
      tpu_db_state_t st;
      logic [7:0] cnt;
      logic tr;
      logic cp;
   } tpu_db_reg_t;

   tpu_db_reg_t s_q;
   tpu_db_reg_t s_d;

   // =====================================================
   // next state: both off while the gap counts down
   always_comb
   begin
      s_d = s_q;
      case (s_q.st)
         TPU_DB_LOW:
         begin
            s_d.tr = 1'b0;
            s_d.cp = 1'b1;
            if (line_i)
            begin
               s_d.cp = 1'b0;
               s_d.cnt = dead_i;
               s_d.st = TPU_DB_WAIT_HI;
            end
         end
         TPU_DB_WAIT_HI:
         begin
            if (!line_i)
               s_d.st = TPU_DB_LOW;
            else if (s_q.cnt == TPU_ZERO8)
            begin
               s_d.tr = 1'b1; // RULE_05
               s_d.st = TPU_DB_HIGH;
            end
            else
               s_d.cnt = s_q.cnt - TPU_ONE8;
         end
         TPU_DB_HIGH:
         begin
            s_d.tr = 1'b1;
            s_d.cp = 1'b0;
            if (!line_i)
            begin
               s_d.tr = 1'b0;
               s_d.cnt = dead_i;
               s_d.st = TPU_DB_WAIT_LO;
            end
         end
         default:
         begin
            if (line_i)
               s_d.st = TPU_DB_HIGH;
            else if (s_q.cnt == TPU_ZERO8)
            begin
               s_d.cp = 1'b1; // RULE_05
               s_d.st = TPU_DB_LOW;
            end
            else
               s_d.cnt = s_q.cnt - TPU_ONE8;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
         s_q <= '{st: TPU_DB_LOW, cnt: TPU_ZERO8, tr: 1'b0, cp: 1'b0};
      else
         s_q <= s_d;
   end

   assign true_o = s_q.tr;
   assign comp_o = s_q.cp;

endmodule : tpu_deadband

// >>> testbench/tpu_timer_pwm_unit_asserts.sv
// Purpose: port checks for the timer and pwm unit
// Assumes: kill levels are not rewritten while killed
// Notes: bound from the bench top file
`timescale 1ns/100ps
module tpu_timer_pwm_unit_asserts
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // pins
   input wire logic kill_pin_i,
   input wire logic pwm_o,
   input wire logic pwm_n_o,
   input wire tpu_pkg::tpu_out_t status_o
);
   import tpu_pkg::*;
   // ========
   // one clock domain, checks quiet in reset
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_excl; !status_o.killed |-> !(pwm_o && pwm_n_o); endproperty
   a_excl: assert property (p_excl) else $error("overlap");
   // break before make, skipped on the cycle after a kill lets go
   property p_gap; ($fell(pwm_o) || $fell(pwm_n_o)) && !status_o.killed
      && !$past(status_o.killed) |-> !pwm_o && !pwm_n_o; endproperty
   a_gap: assert property (p_gap) else $error("no gap");
   property p_kill; kill_pin_i [*3] |=> status_o.killed; endproperty
   a_kill: assert property (p_kill) else $error("kill late");
   property p_free; !kill_pin_i [*3] |=> !status_o.killed; endproperty
   a_free: assert property (p_free) else $error("kill stuck");
   property p_hold; status_o.killed && $past(status_o.killed)
      |-> $stable(pwm_o) && $stable(pwm_n_o); endproperty
   a_hold: assert property (p_hold) else $error("kill moved");
   property p_rdy; psel_i && penable_i |-> pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_err; psel_i && penable_i && paddr_i > 8'h1c |-> pslverr_o;
   endproperty
   a_err: assert property (p_err) else $error("no error");
   property p_rd; !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o);
   endproperty
   a_rd: assert property (p_rd) else $error("read data moved");
   c_kill: cover property ($rose(status_o.killed));
   c_pulse: cover property ($rose(pwm_o));
   c_err: cover property (pslverr_o);
endmodule : tpu_timer_pwm_unit_asserts

// >>> testbench/tpu_pins_model.sv
// Purpose: power switch pair and event pins beside the unit
// Assumes: pins move one clock after the bench asks
// Notes: short_o is sticky so a one-cycle overlap is not lost
`timescale 1ns/100ps
module tpu_pins_model
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // bench requests
   input wire logic cap_lvl_i,
   input wire logic kill_req_i,
   // switch gates
   input wire logic pwm_i,
   input wire logic pwm_n_i,
   // pins and fault flag
   output logic capture_pin_o = 1'b0,
   output logic kill_pin_o = 1'b0,
   output logic short_o = 1'b0
);
   // ========
   // event pins follow requests; both gates on means shoot-through
   always_ff @(posedge core_clk_i)
   begin
      capture_pin_o <= cap_lvl_i;
      kill_pin_o <= kill_req_i;
      short_o <= nrst_i & (short_o | (pwm_i & pwm_n_i));
   end
endmodule : tpu_pins_model

// >>> testbench/tpu_timer_pwm_unit_test.sv
// Purpose: self-checking bench for the timer and pwm unit
// Assumes: zero wait-state apb slave
// Notes: settings drawn from an lfsr with a fixed start
`timescale 1ns/100ps
module tpu_timer_pwm_unit_test;
   import tpu_pkg::*;
   // ========
   // bench signals
   logic core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o;
   logic pslverr_o, capture_pin_i, kill_pin_i, pwm_o, pwm_n_o;
   logic cap_lvl, kill_req, short_o, err;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd, lf, per, c1, dd, a;
   tpu_out_t status_o;
   int error_cnt = 0;
   int checked = 0;
   longint t[3];
   tpu_timer_pwm_unit dut
   (
      .core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .capture_pin_i,
      .kill_pin_i, .pwm_o, .pwm_n_o, .status_o
   );
   tpu_pins_model u_pins
   (
      .core_clk_i, .nrst_i, .cap_lvl_i(cap_lvl), .kill_req_i(kill_req),
      .pwm_i(pwm_o), .pwm_n_i(pwm_n_o), .capture_pin_o(capture_pin_i),
      .kill_pin_o(kill_pin_i), .short_o
   );
   // 4 ns clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   // ========
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; an idle cycle after it keeps drives single
   task automatic bus(input logic w, input logic [7:0] ad,
      input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      @(posedge core_clk_i);
      while (pready_o !== 1'b1 && n++ < 50)
         @(posedge core_clk_i);
      // a slave that never answers counts against the run
      if (n > 50)
         error_cnt++;
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : bus
   // time at which pwm_o is first seen at level v
   task automatic wt(input logic v, input int i);
      int n;
      n = 0;
      while (pwm_o !== v && n++ < 600)
         @(posedge core_clk_i);
      // an edge that never comes is a failure, not a silent time
      if (n > 600)
         error_cnt++;
      t[i] = $time;
   endtask : wt
   // counts, verdict and end of run
   task automatic give_verdict();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // ========
   // main sequence
   initial
   begin
      {psel_i, penable_i, pwrite_i, cap_lvl, kill_req} = 5'h0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      lf = 32'h00013d26;
      nrst_i = 1'b0;
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      // reset values, last word unmapped
      for (int k = 0; k < 9; k++)
      begin
         bus(1'b0, 8'(k * 4), 32'h0);
         chk(rd, k == 1 ? {16'h0, TPU_PERIOD_RST} : 32'h0);
         chk({31'h0, err}, k == 8 ? 32'h1 : 32'h0);
      end
      chk({31'h0, err}, 32'h1);
      // pwm with no dead gap, then a random one
      for (int p = 0; p < 2; p++)
      begin
         lf = nxt(lf);
         per = {28'h0, lf[3:0]} + 32'd20;
         c1 = {29'h0, lf[6:4]} + 32'd6;
         dd = {30'h0, (p == 1 ? lf[9:8] : 2'h0)};
         // stop and rewind first: a count above a shorter new period
         // would otherwise run the whole 16-bit range before wrapping
         bus(1'b1, 8'h00, 32'h0);
         bus(1'b1, 8'h14, 32'h0);
         bus(1'b1, 8'h04, per);
         bus(1'b1, 8'h08, 32'h1);
         bus(1'b1, 8'h0c, c1);
         bus(1'b1, 8'h10, dd);
         bus(1'b1, 8'h00, 32'h41);
         wt(1'b0, 0);
         wt(1'b1, 0);
         wt(1'b0, 1);
         wt(1'b1, 2);
         chk(32'((t[2] - t[0]) / 4), per + 32'h1);
         chk(32'((t[1] - t[0]) / 4), c1 - dd - 32'h2);
      end
      // kill with each safe pair while running
      for (int j = 0; j < 3; j++)
      begin
         bus(1'b1, 8'h00, 32'(1 + j * 16));
         kill_req <= 1'b1;
         repeat (5) @(posedge core_clk_i);
         chk({30'h0, pwm_n_o, pwm_o}, 32'(j));
         bus(1'b0, 8'h1c, 32'h0);
         chk(rd & 32'h2, 32'h2);
         kill_req <= 1'b0;
         repeat (5) @(posedge core_clk_i);
      end
      // one-shot stops at the period with the terminal flag
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h14, 32'h0);
      // clear the terminal flag left by the pwm runs
      bus(1'b1, 8'h1c, 32'h8);
      bus(1'b0, 8'h1c, 32'h0);
      chk(rd & 32'h8, 32'h0);
      bus(1'b1, 8'h00, 32'h43);
      repeat (per + 8) @(posedge core_clk_i);
      bus(1'b0, 8'h1c, 32'h0);
      chk(rd & 32'h9, 32'h8);
      // two reads three cycles apart see the count step by three
      bus(1'b1, 8'h00, 32'h41);
      bus(1'b0, 8'h14, 32'h0);
      a = rd;
      bus(1'b0, 8'h14, 32'h0);
      chk(rd - a, 32'h3);
      // capture on rising then falling edge, counter held
      for (int m = 0; m < 2; m++)
      begin
         lf = nxt(lf);
         bus(1'b1, 8'h00, 32'(4 + m * 8));
         bus(1'b1, 8'h14, lf & 32'hffff);
         cap_lvl <= ~cap_lvl;
         repeat (6) @(posedge core_clk_i);
         bus(1'b0, 8'h18, 32'h0);
         chk(rd, lf & 32'hffff);
      end
      chk({31'h0, short_o}, 32'h0);
      give_verdict();
   end
   // watchdog at 20000 cycles, far beyond the few hundred cycles needed
   initial
   begin
      #80000;
      error_cnt++;
      give_verdict();
   end
endmodule : tpu_timer_pwm_unit_test
bind tpu_timer_pwm_unit tpu_timer_pwm_unit_asserts u_chk
(
   .core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .prdata_o, .pready_o, .pslverr_o, .kill_pin_i, .pwm_o, .pwm_n_o,
   .status_o
);
